// *** shared/fws_cfg.svh ***
// Constants of the flash status poller: register offsets, fields, timing.
// Assumes it is included by package and design files by bare name.
// Behaviour
// - Host combines toggle status and sector toggle bits for mode and sector; the poller compares only the toggle status bit.
// - Host reads status twice; unchanged toggle means done.
// - Toggling with timing limit high: recheck; still toggling means failure, reset.
// - Polling resumed after other tasks restarts from the first double read.
// - After timing limit failure host writes the reset command.
// - Host may skip erase timer check only if commands under 50 us apart.
// - Host checks erase timer flag before and after each added sector erase.
// - Host polls at the programmed address or a sector selected for erase.
`ifndef FWS_CFG_SVH
`define FWS_CFG_SVH
`define FWS_REG_CTRL 8'h00
`define FWS_REG_ADDR 8'h04
`define FWS_REG_WDATA 8'h08
`define FWS_REG_STAT 8'h0c
`define FWS_REG_LAST 8'h10
`define FWS_CMD_READ 3'h1
`define FWS_CMD_WRITE 3'h2
`define FWS_CMD_POLL 3'h3
`define FWS_CMD_ERCHK 3'h4
`define FWS_BIT_POLL 7
`define FWS_BIT_TOGGLE 6
`define FWS_BIT_LIMIT 5
`define FWS_BIT_ETIMER 3
`define FWS_BIT_STOGGLE 2
`define FWS_RESET_ADDR 24'h000000
`define FWS_RESET_DATA 16'h00f0
`define FWS_CLK_MHZ 250
`define FWS_T_STROBE_NS 60
`define FWS_STROBE_CYC ((`FWS_T_STROBE_NS * `FWS_CLK_MHZ + 999) / 1000)
`endif

// *** shared/fws_pkg.sv ***
// Types of the flash status poller.
// Assumes fws_cfg.svh sits on the include path.
`include "fws_cfg.svh"
package fws_pkg;
  // Flash pin bundle driven by the controller
  typedef struct packed {
    logic ce_n;
    logic oe_n;
    logic we_n;
    logic [23:0] addr;
    logic [15:0] dq_out;
    logic dq_oe;
  } fws_pins_type;
  // Poll outcome
  typedef enum logic [1:0] {FWS_RES_NONE, FWS_RES_DONE, FWS_RES_FAIL, FWS_RES_LATE}
    fws_result_type;
  // Bus cycle states of the pin sequencer
  typedef enum {FWS_CY_IDLE, FWS_CY_SETUP, FWS_CY_STROBE, FWS_CY_HOLD} fws_cy_type;
  // Polling states
  typedef enum {FWS_PL_IDLE, FWS_PL_FIRST, FWS_PL_SECOND, FWS_PL_RECHECK, FWS_PL_RESET,
    FWS_PL_EPRE, FWS_PL_EWR, FWS_PL_EPOST} fws_pl_type;
endpackage

// *** core/fws_cycle.sv ***
// One asynchronous flash bus cycle: setup, strobe low, hold.
// Assumes dq_in is synchronous to mclk and the strobe time covers access time.
`timescale 1ns/10ps
`include "fws_cfg.svh"
module fws_cycle import fws_pkg::*; #(
  parameter int STROBE_CYC = `FWS_STROBE_CYC
) (
  input wire logic mclk,
  input wire logic rst,
  input wire logic start,
  input wire logic wr,
  input wire logic [23:0] addr,
  input wire logic [15:0] wdata,
  input wire logic [15:0] dq_in,
  output logic busy,
  output logic done,
  output logic [15:0] rdata,
  output fws_pins_type pins
);
  typedef struct packed {
    fws_cy_type st;
    logic [7:0] cnt;
    logic wr;
    logic done;
    logic [15:0] rdata;
    fws_pins_type pins;
  } fws_cyst_type;
  fws_cyst_type s_q, s_d;

  // Every read is a full ce/oe cycle so the device counts it as a new read
  always_comb begin
    s_d = s_q;
    s_d.done = 1'b0;
    case (s_q.st)
      FWS_CY_IDLE: begin
        if (start) begin
          s_d.st = FWS_CY_SETUP;
          s_d.wr = wr;
          s_d.pins.addr = addr;
          s_d.pins.dq_out = wdata;
          s_d.pins.dq_oe = wr;
          s_d.pins.ce_n = 1'b0;
        end
      end
      FWS_CY_SETUP: begin
        s_d.st = FWS_CY_STROBE;
        s_d.cnt = 8'(STROBE_CYC);
        s_d.pins.oe_n = s_q.wr;
        s_d.pins.we_n = !s_q.wr;
      end
      FWS_CY_STROBE: begin
        if (s_q.cnt <= 8'h01) begin
          s_d.st = FWS_CY_HOLD;
          s_d.rdata = dq_in;
          s_d.pins.oe_n = 1'b1;
          s_d.pins.we_n = 1'b1;
        end else begin
          s_d.cnt = s_q.cnt - 8'h01;
        end
      end
      FWS_CY_HOLD: begin
        s_d.st = FWS_CY_IDLE;
        s_d.pins.ce_n = 1'b1;
        s_d.pins.dq_oe = 1'b0;
        s_d.done = 1'b1;
      end
      default: s_d.st = FWS_CY_IDLE;
    endcase
  end

  // State register
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      s_q <= '{st: FWS_CY_IDLE, cnt: 8'h00, wr: 1'b0, done: 1'b0, rdata: 16'h0000,
        pins: '{ce_n: 1'b1, oe_n: 1'b1, we_n: 1'b1, addr: 24'h000000,
        dq_out: 16'h0000, dq_oe: 1'b0}};
    end else begin
      s_q <= s_d;
    end
  end

  assign busy = (s_q.st != FWS_CY_IDLE);
  assign done = s_q.done;
  assign rdata = s_q.rdata;
  assign pins = s_q.pins;

  strobe_len_a: assert property (@(posedge mclk) disable iff (rst)
    $fell(s_q.pins.oe_n) |-> !s_q.pins.oe_n [*2])
    else $error("read strobe too short");
endmodule

// *** core/fws_poller.sv ***
// Flash status poller: AHB-Lite registers, pin cycles, toggle polling.
// Assumes one AHB-Lite master, word transfers only, dq_in synchronous.
//
// The implementer's own choices: the placing of the registers and register access over AHB-Lite.
`timescale 1ns/10ps
`include "fws_cfg.svh"
module fws_poller import fws_pkg::*; #(
  parameter int STROBE_CYC = `FWS_STROBE_CYC
) (
  input wire logic mclk,
  input wire logic rst,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic [31:0] hrdata,
  output logic hreadyout,
  output logic hresp,
  output logic flash_ce_n,
  output logic flash_oe_n,
  output logic flash_we_n,
  output logic [23:0] flash_addr,
  output logic [15:0] flash_dq_out,
  output logic flash_dq_oe,
  input wire logic [15:0] flash_dq_in
);
  typedef struct packed {
    logic wpend;
    logic [7:0] waddr;
    fws_pl_type pl;
    logic go;
    logic go_wr;
    logic [23:0] addr;
    logic [15:0] wdata;
    logic [15:0] last;
    logic first_tog;
    logic busy;
    fws_result_type res;
    logic [31:0] hrdata;
  } fws_st_type;
  fws_st_type s_q, s_d;
  logic cy_busy;
  logic cy_done;
  logic [15:0] cy_rdata;
  fws_pins_type pins;
  logic tog_same;

  fws_cycle #(.STROBE_CYC(STROBE_CYC)) u_cycle (
    .mclk(mclk),
    .rst(rst),
    .start(s_q.go),
    .wr(s_q.go_wr),
    .addr(s_q.addr),
    .wdata(s_q.wdata),
    .dq_in(flash_dq_in),
    .busy(cy_busy),
    .done(cy_done),
    .rdata(cy_rdata),
    .pins(pins)
  );

  // Toggle status bit compared between consecutive reads
  assign tog_same = (cy_rdata[`FWS_BIT_TOGGLE] == s_q.last[`FWS_BIT_TOGGLE]);

  always_comb begin
    s_d = s_q;
    s_d.go = 1'b0;
    // Bus address phase latched; data taken next cycle, zero wait states
    s_d.wpend = hsel && hready && htrans[1] && hwrite;
    if (hsel && hready && htrans[1]) begin
      s_d.waddr = haddr[7:0];
      case (haddr[7:0])
        `FWS_REG_ADDR: s_d.hrdata = {8'h00, s_q.addr};
        `FWS_REG_WDATA: s_d.hrdata = {16'h0000, s_q.wdata};
        `FWS_REG_STAT: s_d.hrdata = {29'h0, s_q.res, s_q.busy};
        `FWS_REG_LAST: s_d.hrdata = {16'h0000, s_q.last}; // both toggle bits
        default: s_d.hrdata = 32'h00000000;
      endcase
    end
    if (s_q.wpend) begin
      case (s_q.waddr)
        `FWS_REG_ADDR: s_d.addr = hwdata[23:0];
        `FWS_REG_WDATA: s_d.wdata = hwdata[15:0];
        `FWS_REG_CTRL: begin
          // Commands while busy are dropped; software polls the busy bit
          if (!s_q.busy) begin
            s_d.busy = 1'b1;
            s_d.res = FWS_RES_NONE;
            s_d.go = 1'b1;
            s_d.go_wr = (hwdata[2:0] == `FWS_CMD_WRITE);
            case (hwdata[2:0])
              `FWS_CMD_POLL: s_d.pl = FWS_PL_FIRST; // fresh double read
              `FWS_CMD_ERCHK: s_d.pl = FWS_PL_EPRE; // never skipped
              default: s_d.pl = FWS_PL_IDLE;
            endcase
          end
        end
        default: ;
      endcase
    end
    // Sequencer, advanced once per finished pin cycle
    if (cy_done) begin
      s_d.last = cy_rdata;
      s_d.go = 1'b1;
      case (s_q.pl)
        FWS_PL_IDLE: begin
          s_d.go = 1'b0;
          s_d.busy = 1'b0;
        end
        FWS_PL_FIRST: s_d.pl = FWS_PL_SECOND;
        FWS_PL_SECOND, FWS_PL_RECHECK: begin
          if (s_q.pl == FWS_PL_RECHECK && s_q.first_tog) begin
            // First read of a fresh recheck pair: nothing to compare yet
            // Comparing with the read before the limit could flag a finished
            // operation whose array data differs in the toggle position
            s_d.first_tog = 1'b0;
          end else if (tog_same) begin
            // Not toggling: operation over
            s_d.go = 1'b0;
            s_d.busy = 1'b0;
            s_d.pl = FWS_PL_IDLE;
            s_d.res = FWS_RES_DONE;
          end else if (s_q.pl == FWS_PL_RECHECK) begin
            // Still toggling after limit seen: failure, reset
            s_d.pl = FWS_PL_RESET;
            s_d.go_wr = 1'b1;
            s_d.addr = `FWS_RESET_ADDR;
            s_d.wdata = `FWS_RESET_DATA;
          end else if (cy_rdata[`FWS_BIT_LIMIT]) begin
            s_d.pl = FWS_PL_RECHECK;
            s_d.first_tog = 1'b1;
          end
        end
        FWS_PL_RESET: begin
          s_d.go = 1'b0;
          s_d.busy = 1'b0;
          s_d.pl = FWS_PL_IDLE;
          s_d.res = FWS_RES_FAIL;
        end
        FWS_PL_EPRE: begin
          // Timer already expired: the added erase would be ignored
          if (cy_rdata[`FWS_BIT_ETIMER]) begin
            s_d.go = 1'b0;
            s_d.busy = 1'b0;
            s_d.pl = FWS_PL_IDLE;
            s_d.res = FWS_RES_LATE;
          end else begin
            s_d.pl = FWS_PL_EWR;
            s_d.go_wr = 1'b1;
          end
        end
        FWS_PL_EWR: begin
          s_d.pl = FWS_PL_EPOST;
          s_d.go_wr = 1'b0;
        end
        FWS_PL_EPOST: begin
          // High on the check after means possibly not accepted
          s_d.go = 1'b0;
          s_d.busy = 1'b0;
          s_d.pl = FWS_PL_IDLE;
          s_d.res = cy_rdata[`FWS_BIT_ETIMER] ? FWS_RES_LATE : FWS_RES_DONE;
        end
        default: begin
          s_d.go = 1'b0;
          s_d.pl = FWS_PL_IDLE;
        end
      endcase
    end
    // Poll reads never write; judged on the next state so the reset write survives
    if (s_d.pl == FWS_PL_FIRST || s_d.pl == FWS_PL_SECOND || s_d.pl == FWS_PL_RECHECK)
      s_d.go_wr = 1'b0;
  end

  // State register
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      s_q <= '{wpend: 1'b0, waddr: 8'h00, pl: FWS_PL_IDLE, go: 1'b0, go_wr: 1'b0,
        addr: 24'h000000, wdata: 16'h0000, last: 16'h0000, first_tog: 1'b0,
        busy: 1'b0, res: FWS_RES_NONE, hrdata: 32'h00000000};
    end else begin
      s_q <= s_d;
    end
  end

  // Outputs straight from flip-flops; hreadyout and hresp tied constant
  assign hrdata = s_q.hrdata;
  assign hreadyout = 1'b1;
  assign hresp = 1'b0;
  assign flash_ce_n = pins.ce_n;
  assign flash_oe_n = pins.oe_n;
  assign flash_we_n = pins.we_n;
  assign flash_addr = pins.addr;
  assign flash_dq_out = pins.dq_out;
  assign flash_dq_oe = pins.dq_oe;

  // Poll sequence checks; every status read is a full pin cycle of its own
  poll_done_a: assert property (@(posedge mclk) disable iff (rst)
    cy_done && s_q.pl == FWS_PL_SECOND && tog_same |=> s_q.res == FWS_RES_DONE && !s_q.busy)
    else $error("unchanged toggle not reported done");
  limit_recheck_a: assert property (@(posedge mclk) disable iff (rst)
    cy_done && s_q.pl == FWS_PL_SECOND && !tog_same && cy_rdata[`FWS_BIT_LIMIT]
    |=> s_q.pl == FWS_PL_RECHECK && s_q.first_tog)
    else $error("limit flag not rechecked");
  fresh_pair_a: assert property (@(posedge mclk) disable iff (rst)
    cy_done && s_q.pl == FWS_PL_RECHECK && s_q.first_tog
    |=> s_q.pl == FWS_PL_RECHECK && s_q.go && !s_q.go_wr)
    else $error("recheck pair cut short");
  fail_reset_a: assert property (@(posedge mclk) disable iff (rst)
    cy_done && s_q.pl == FWS_PL_RECHECK && !s_q.first_tog && !tog_same
    |=> s_q.go && s_q.go_wr && s_q.wdata == `FWS_RESET_DATA)
    else $error("reset command not issued");
  restart_a: assert property (@(posedge mclk) disable iff (rst)
    s_q.pl == FWS_PL_IDLE ##1 s_q.pl == FWS_PL_SECOND |-> 0)
    else $error("polling skipped first read");
  late_erase_a: assert property (@(posedge mclk) disable iff (rst)
    cy_done && s_q.pl == FWS_PL_EPRE && cy_rdata[`FWS_BIT_ETIMER]
    |=> s_q.res == FWS_RES_LATE && !s_q.go)
    else $error("late sector erase not blocked");
  poll_addr_a: assert property (@(posedge mclk) disable iff (rst)
    s_q.go && !s_q.go_wr && s_q.pl != FWS_PL_IDLE |-> s_q.addr == $past(s_q.addr))
    else $error("poll address moved");
  read_only_poll_a: assert property (@(posedge mclk) disable iff (rst)
    s_q.pl == FWS_PL_SECOND |-> !pins.dq_oe)
    else $error("bus driven during poll read");
  cmd_busy_a: assert property (@(posedge mclk) disable iff (rst)
    s_q.busy && !$past(s_q.busy) |-> s_q.res == FWS_RES_NONE)
    else $error("stale result at command start");
  // A dropped start would merge two reads into one and hide a toggle
  start_idle_a: assert property (@(posedge mclk) disable iff (rst)
    s_q.go |-> !cy_busy)
    else $error("pin cycle started while busy");
  cover_done_c: cover property (@(posedge mclk) s_q.res == FWS_RES_DONE);
  cover_recheck_c: cover property (@(posedge mclk) s_q.pl == FWS_PL_RECHECK && !s_q.first_tog);
  cover_reset_c: cover property (@(posedge mclk) s_q.go && s_q.go_wr && s_q.pl == FWS_PL_RESET);
  cover_fail_c: cover property (@(posedge mclk) s_q.res == FWS_RES_FAIL);
  cover_late_c: cover property (@(posedge mclk) s_q.res == FWS_RES_LATE);
endmodule

// *** tb/fws_flash_model.sv ***
// Behavioural flash device: status byte while an operation runs, array word after.
// Assumes the controller holds ce_n low around each oe_n or we_n strobe.
`timescale 1ns/10ps
module fws_flash_model (
  input wire logic ce_n,
  input wire logic oe_n,
  input wire logic we_n,
  input wire logic [23:0] addr,
  input wire logic [15:0] dq_out,
  output logic [15:0] dq_in
);
  int busy_left = 0;
  int writes = 0;
  int resets = 0;
  logic stuck = 1'b0;
  logic limit = 1'b0;
  logic etimer = 1'b0;
  logic etimer_wr = 1'b0;
  logic tog = 1'b0;
  logic [15:0] word = 16'h5a3c;
  logic [15:0] last = 16'h0000;
  logic [23:0] wr_addr = 24'h000000;
  logic [15:0] wr_data = 16'h0000;
  logic active;
  logic [15:0] drive;
  // Erase-style status: polling bit 0, both toggle bits follow tog
  always @* begin
    active = busy_left > 0 || stuck;
    drive = active ? {8'h00, 1'b0, tog, limit, 1'b0, etimer, tog, 2'b00} : word;
    if (!ce_n && !oe_n) begin
      last = drive;
    end
  end
  // Released bus shows the inverse so a stale sample cannot pass
  assign dq_in = (!ce_n && !oe_n) ? drive : ~last;
  // Each finished read flips the toggle bits while busy
  always @(posedge oe_n) begin
    if (!ce_n && active) begin
      tog = ~tog;
      if (busy_left > 0) begin
        busy_left--;
      end
    end
  end
  // Writes: reset command clears a failed operation
  always @(posedge we_n) begin
    if (!ce_n) begin
      writes++;
      wr_addr = addr;
      wr_data = dq_out;
      etimer = etimer_wr;
      if (addr == 24'h000000 && dq_out == 16'h00f0) begin
        stuck = 1'b0;
        limit = 1'b0;
        resets++;
      end
    end
  end
  task automatic start(int n, logic s, logic l, logic e0, logic e1);
    busy_left = n;
    stuck = s;
    limit = l;
    etimer = e0;
    etimer_wr = e1;
  endtask
endmodule

// *** tb/test_flash_write_status_reporting.sv ***
// Testbench of the flash status poller with a behavioural flash model.
// Assumes the poller answers with zero wait states as its note says.
`timescale 1ns/10ps
`include "fws_cfg.svh"
module test_flash_write_status_reporting import fws_pkg::*; ;
  logic mclk = 1'b0;
  logic rst = 1'b1;
  logic [31:0] haddr = 32'h0;
  logic [1:0] htrans = 2'h0;
  logic hwrite = 1'b0;
  logic [31:0] hwdata = 32'h0;
  logic [31:0] hrdata;
  logic hreadyout;
  logic hresp;
  logic ce_n, oe_n, we_n, dq_oe;
  logic [23:0] faddr;
  logic [15:0] fdout, fdin;
  logic [31:0] rd, st;
  int miscompares = 0;
  int compares = 0;
  int w;
  int n;
  logic lim;
  fws_poller #(.STROBE_CYC(2)) dut (.mclk(mclk), .rst(rst), .hsel(1'b1), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hreadyout),
    .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp), .flash_ce_n(ce_n), .flash_oe_n(oe_n),
    .flash_we_n(we_n), .flash_addr(faddr), .flash_dq_out(fdout), .flash_dq_oe(dq_oe),
    .flash_dq_in(fdin));
  fws_flash_model flash (.ce_n(ce_n), .oe_n(oe_n), .we_n(we_n), .addr(faddr),
    .dq_out(fdout), .dq_in(fdin));
  initial begin
    forever #2 mclk = ~mclk;
  end
  task automatic check(logic [31:0] seen, logic [31:0] exp);
    compares++;
    if (seen !== exp) begin
      miscompares++;
      $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic print_verdict();
    $display("compares %0d miscompares %0d", compares, miscompares);
    if (miscompares == 0 && compares > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask
  // Bounded wait for hready sampled high at a rising edge
  task automatic wait_ready();
    int n;
    n = 0;
    do begin
      @(posedge mclk);
      n++;
    end while (hreadyout !== 1'b1 && n < 100);
    if (hreadyout !== 1'b1) begin
      miscompares++;
      print_verdict();
    end
  endtask
  task automatic bus(logic wr, logic [7:0] a, logic [31:0] wd, output logic [31:0] d);
    htrans <= 2'h2;
    haddr <= {24'h0, a};
    hwrite <= wr;
    wait_ready();
    htrans <= 2'h0;
    hwdata <= wd;
    wait_ready();
    d = hrdata;
  endtask
  // Issue one command and poll busy; gives STAT back
  task automatic run(logic [2:0] cmd, logic [23:0] a, logic [15:0] d, output logic [31:0] s);
    int n;
    bus(1'b1, `FWS_REG_ADDR, {8'h0, a}, s);
    bus(1'b1, `FWS_REG_WDATA, {16'h0, d}, s);
    bus(1'b1, `FWS_REG_CTRL, {29'h0, cmd}, s);
    n = 0;
    do begin
      bus(1'b0, `FWS_REG_STAT, 32'h0, s);
      n++;
    end while (s[0] !== 1'b0 && n < 2000);
    if (s[0] !== 1'b0) begin
      miscompares++;
      print_verdict();
    end
  endtask
  // Expected STAT: failure only when still toggling with the limit flag up
  function automatic logic [31:0] exp_stat(logic stk, logic lim, logic late);
    return {29'h0, late ? FWS_RES_LATE : (stk && lim) ? FWS_RES_FAIL : FWS_RES_DONE, 1'b0};
  endfunction
  initial begin
    void'($urandom(32'h691a4faf));
    repeat (8) @(posedge mclk);
    check({ce_n, oe_n, we_n, dq_oe}, 4'he);
    rst <= 1'b0;
    @(posedge mclk);
    bus(1'b0, 8'h14, 32'h0, rd);
    check(rd, 32'h0);
    check(hresp, 32'h0);
    run(`FWS_CMD_READ, 24'h000123, 16'h0, st);
    bus(1'b0, `FWS_REG_LAST, 32'h0, rd);
    check(rd[15:0], 16'h5a3c);
    w = $urandom;
    run(`FWS_CMD_WRITE, w[23:0], w[31:16], st);
    check({flash.wr_addr, flash.wr_data}, {w[23:0], w[31:16]});
    // Random toggle lengths; limit flag only with runs that end before the recheck pair
    for (int i = 0; i < 8; i++) begin
      w = $urandom;
      lim = w[8];
      n = lim ? (w[1:0] % 3) : (i == 7 ? 25 : w[3:0] % 10);
      flash.start(n, 1'b0, lim, 1'b0, 1'b0);
      run(`FWS_CMD_POLL, 24'h000040, 16'h0, st);
      check(st, exp_stat(1'b0, lim, 1'b0));
      check(flash.busy_left, 0);
    end
    // Toggling forever with the limit flag: failure and reset command
    flash.start(0, 1'b1, 1'b1, 1'b0, 1'b0);
    run(`FWS_CMD_POLL, 24'h000040, 16'h0, st);
    check(st, exp_stat(1'b1, 1'b1, 1'b0));
    check(flash.resets, 1);
    check(flash.stuck, 1'b0);
    // Added sector erase: accepted, late, and timer already expired
    w = flash.writes;
    // Erase in its acceptance window, so status (with the timer flag) is shown
    flash.start(10, 1'b0, 1'b0, 1'b0, 1'b0);
    run(`FWS_CMD_ERCHK, 24'h020000, 16'h0030, st);
    check(st, exp_stat(1'b0, 1'b0, 1'b0));
    check(flash.writes, w + 1);
    flash.start(10, 1'b0, 1'b0, 1'b0, 1'b1);
    run(`FWS_CMD_ERCHK, 24'h040000, 16'h0030, st);
    check(st, exp_stat(1'b0, 1'b0, 1'b1));
    flash.start(10, 1'b0, 1'b0, 1'b1, 1'b1);
    run(`FWS_CMD_ERCHK, 24'h060000, 16'h0030, st);
    check(st, exp_stat(1'b0, 1'b0, 1'b1));
    check(flash.writes, w + 2);
    print_verdict();
  end
endmodule
